/* File: hdl/itw_top.sv */
// Module: interval timer, watchdog, clock select and their APB register file
// Operation
// - Eight-bit interval counter runs from reset and cannot be stopped by software.
// - Counter steps per selected tap pulse; wrap from ff sets interval flag.
// - Three-bit source field picks tap: oscillator divided by 8 up to 1024.
// - Writing interval-clear zeroes the counter; the bit self-clears after one cycle.
// - One address: reads return the interval count, writes load the control register.
// - Stop with rc select set enters rc mode; only rc, timer, watchdog run.
// - Seven-bit watchdog counter requests when equal to compare low seven bits.
// - Match gives reset if reset-select is one, else sets watchdog flag.
// - Bit 7 of compare clears watchdog counter and self-clears after one cycle.
// - Reset-select is control bit 4 and resets to one.
// - Normally the watchdog steps once per interval period.
// - In rc mode the watchdog counts rc periods divided by 256.
// - Prescaled watchdog freezes during stop and resumes from its held value.
// - After reset-select is set from zero, the watchdog counts only after the interval timer has been cleared.
// - Peripheral prescaler gives undivided to divide-by-4096 taps, gated off by stop.
// - Two bits select the system clock tap; reset selects the fastest one.
`timescale 1ns/1ps

module itw_top
  import itw_pkg::*;
#(
  parameter int unsigned INTERVAL_CLEAR_BIT = DEF_INTERVAL_CLEAR_BIT,
  parameter int unsigned RC_SELECT_BIT = DEF_RC_SELECT_BIT
)(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // CPU power state events, one-cycle pulses
  input wire logic stop_enter_in,
  input wire logic stop_release_in,
  // Internal rc oscillator, asynchronous
  input wire logic rc_osc_in,
  // Clock enables
  output logic [TICK_W-1:0] periph_tick_out,
  output logic sys_clk_en_out,
  // Events and state
  output logic interval_irq_flag_out,
  output logic watchdog_irq_flag_out,
  output logic watchdog_reset_out,
  output logic rc_mode_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  itw_mode_t mode_q, mode_d;
  logic [7:0] ctl_q;
  logic [7:0] cmp_q;
  logic [SCS_W-1:0] scs_q;
  logic [INTERVAL_W-1:0] bit_cnt_q, bit_cnt_d;
  logic [WDT_W-1:0] wdt_cnt_q, wdt_cnt_d;
  logic wdt_run_q;
  logic iflag_q, wflag_q;
  logic wdt_rst_q;
  logic rc_s1_q, rc_s2_q, rc_s3_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [TICK_W-1:0] ticks;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Named strobes; writes take effect in the access cycle only
  wire setup = psel_in & ~penable_in;
  wire wr = psel_in & penable_in & pwrite_in;
  wire sel_ctl = (paddr_in == ADDR_TIMER_CONTROL);
  wire sel_cmp = (paddr_in == ADDR_WATCHDOG_COMPARE);
  wire sel_scs = (paddr_in == ADDR_SYSTEM_CLOCK_SELECT);
  wire sel_sta = (paddr_in == ADDR_STATUS);
  wire mapped = sel_ctl | sel_cmp | sel_scs | sel_sta;
  wire wr_ctl = wr & sel_ctl;
  wire wr_cmp = wr & sel_cmp;
  wire wr_scs = wr & sel_scs;
  wire wr_sta = wr & sel_sta;

  // Control fields
  wire [SRC_W-1:0] src = ctl_q[SRC_LSB +: SRC_W];
  wire rst_sel = ctl_q[WDT_RESET_SELECT_BIT];
  wire rc_sel = ctl_q[RC_SELECT_BIT];
  wire bit_clr = ctl_q[INTERVAL_CLEAR_BIT];
  wire wdt_clr = cmp_q[WDT_CLEAR_BIT];

  // Read mux; the control address reads back the count, not the control
  wire [7:0] sta_byte = {4'h0, (mode_q != ITW_MODE_RUN), (mode_q == ITW_MODE_RC), wflag_q, iflag_q};
  wire [31:0] rdata = sel_ctl ? {24'h0, bit_cnt_q} :
    sel_cmp ? {24'h0, cmp_q} :
    sel_scs ? {30'h0, scs_q} :
    sel_sta ? {24'h0, sta_byte} : 32'h0;

  // Read data latched in setup so it is a flop in the access cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= rdata;
      pslverr_q <= ~mapped;
    end
  end

  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q;
  assign pready_out = psel_in & penable_in;

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------

  // Control: clear bit drops by itself one cycle after the write
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctl_q <= TIMER_CONTROL_RST;
    end else if (wr_ctl) begin
      ctl_q <= pwdata_in[7:0];
    end else begin
      ctl_q[INTERVAL_CLEAR_BIT] <= 1'b0;
    end
  end

  // Compare: bit 7 is a one-cycle clear command
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmp_q <= WATCHDOG_COMPARE_RST;
    end else if (wr_cmp) begin
      cmp_q <= pwdata_in[7:0];
    end else begin
      cmp_q[WDT_CLEAR_BIT] <= 1'b0;
    end
  end

  // System clock select, fastest tap after reset
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scs_q <= SYSTEM_CLOCK_SELECT_RST;
    end else if (wr_scs) begin
      scs_q <= pwdata_in[SCS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Stop and rc modes
  // ----------------------------------------------------------------

  // Rc select is sampled at the stop event itself
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ITW_MODE_RUN: begin
        if (stop_enter_in) begin
          mode_d = rc_sel ? ITW_MODE_RC : ITW_MODE_HOLD;
        end
      end
      ITW_MODE_HOLD, ITW_MODE_RC: begin
        if (stop_release_in) begin
          mode_d = ITW_MODE_RUN;
        end
      end
      default: begin
        mode_d = ITW_MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_q <= ITW_MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Rc oscillator synchroniser; only the second and third stages feed the edge
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_osc_in;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  wire rc_edge = rc_s2_q & ~rc_s3_q;
  wire running = (mode_q == ITW_MODE_RUN);

  // ----------------------------------------------------------------
  // Prescaler and clock enables
  // ----------------------------------------------------------------

  // Stop gates the whole divider chain off
  itw_prescaler u_prescaler (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(running),
    .tick_out(ticks)
  );

  wire [3:0] tap_idx = INTERVAL_TAP_BASE + {1'b0, src};
  wire [3:0] sys_idx = SYSTEM_TAP_BASE + {2'b00, scs_q};
  assign periph_tick_out = ticks;
  assign sys_clk_en_out = ticks[sys_idx];

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------

  // In rc mode the counter takes rc edges, so each wrap is 256 rc periods
  wire bit_step = running ? ticks[tap_idx] : ((mode_q == ITW_MODE_RC) & rc_edge);
  wire bit_wrap = bit_step & ~bit_clr & (bit_cnt_q == 8'hff);

  always_comb begin
    bit_cnt_d = bit_cnt_q;
    if (bit_clr) begin
      bit_cnt_d = 8'h00;
    end else if (bit_step) begin
      bit_cnt_d = bit_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt_q <= 8'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------

  // Arming reset-select halts counting until the interval timer is cleared,
  // which bounds the first-period error by one interval period
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_run_q <= 1'b1;
    end else if (bit_clr) begin
      wdt_run_q <= 1'b1;
    end else if (wr_ctl & pwdata_in[WDT_RESET_SELECT_BIT] & ~rst_sel) begin
      wdt_run_q <= 1'b0;
    end
  end

  // One step per interval wrap; hold mode has no wraps, so it freezes
  wire wdt_adv = bit_wrap & wdt_run_q;
  wire [WDT_W-1:0] wdt_next = wdt_cnt_q + 7'h01;
  wire wdt_hit = wdt_adv & ~wdt_clr & (wdt_next == cmp_q[WDT_W-1:0]);

  // Restart on a match so the timer mode repeats at a fixed interval
  always_comb begin
    wdt_cnt_d = wdt_cnt_q;
    if (wdt_clr || wdt_hit) begin
      wdt_cnt_d = 7'h00;
    end else if (wdt_adv) begin
      wdt_cnt_d = wdt_next;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_cnt_q <= 7'h00;
    end else begin
      wdt_cnt_q <= wdt_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Events and flags
  // ----------------------------------------------------------------

  // Set wins over a write-one-to-clear in the same cycle
  wire iflag_clr = wr_sta & pwdata_in[STA_INTERVAL_FLAG_BIT];
  wire wflag_clr = wr_sta & pwdata_in[STA_WATCHDOG_FLAG_BIT];

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iflag_q <= 1'b0;
      wflag_q <= 1'b0;
      wdt_rst_q <= 1'b0;
    end else begin
      iflag_q <= bit_wrap | (iflag_q & ~iflag_clr);
      wflag_q <= (wdt_hit & ~rst_sel) | (wflag_q & ~wflag_clr);
      wdt_rst_q <= wdt_hit & rst_sel;
    end
  end

  assign interval_irq_flag_out = iflag_q;
  assign watchdog_irq_flag_out = wflag_q;
  assign watchdog_reset_out = wdt_rst_q;
  assign rc_mode_out = (mode_q == ITW_MODE_RC);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_ctl_clear_write;
    wr_ctl && pwdata_in[INTERVAL_CLEAR_BIT];
  endsequence

  sequence s_cmp_clear_write;
    wr_cmp && pwdata_in[WDT_CLEAR_BIT];
  endsequence

  a_bit_free_run: assert property (
    (running && bit_step && !bit_clr) |=> (bit_cnt_q == $past(bit_cnt_q) + 8'h01))
    else $error("interval counter missed a step");

  a_bit_wrap_flag: assert property (
    (bit_wrap && !wr_sta) |=> (iflag_q && bit_cnt_q == 8'h00))
    else $error("interval wrap did not set its flag");

  a_tap_min_gap: assert property (
    (running && bit_step) |=> (!bit_step || mode_q == ITW_MODE_RC) [*7])
    else $error("interval steps closer than eight cycles");

  a_bit_clear_seq: assert property (
    s_ctl_clear_write |=> bit_clr ##1 (!bit_clr && bit_cnt_q == 8'h00))
    else $error("interval clear did not zero and self-clear");

  a_shared_addr_read: assert property (
    (setup && sel_ctl) |=> (prdata_out == {24'h0, $past(bit_cnt_q)}))
    else $error("control address did not read the interval count");

  a_rc_mode_entry: assert property (
    (running && stop_enter_in && rc_sel) |=> (rc_mode_out && periph_tick_out == '0))
    else $error("stop with rc select did not enter rc mode");

  a_wdt_match_reset: assert property (
    (wdt_hit && rst_sel) |=> (watchdog_reset_out && wdt_cnt_q == 7'h00) ##1 !watchdog_reset_out)
    else $error("watchdog match did not pulse reset");

  a_wdt_match_flag: assert property (
    (wdt_adv && !wdt_clr && !rst_sel && wdt_next == cmp_q[WDT_W-1:0] && !wr_sta) |=> wflag_q)
    else $error("watchdog match did not set its flag");

  a_wdt_clear_seq: assert property (
    s_cmp_clear_write |=> wdt_clr ##1 (!wdt_clr && wdt_cnt_q == 7'h00))
    else $error("watchdog clear did not zero and self-clear");

  a_wdt_hold_stop: assert property (
    (mode_q == ITW_MODE_HOLD && !wdt_clr) |=> $stable(wdt_cnt_q))
    else $error("watchdog moved during stop");

  a_wdt_wait_clear: assert property (
    (!wdt_run_q && !wdt_clr) |=> $stable(wdt_cnt_q))
    else $error("watchdog counted before interval clear");

endmodule

/* File: hdl/itw_pkg.sv */
// Package: register map, field layout, reset values and modes of the interval timer watchdog
package itw_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the APB slave (low eight address bits)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hec;
  localparam logic [7:0] ADDR_WATCHDOG_COMPARE = 8'hf0;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT = 8'hf4;
  localparam logic [7:0] ADDR_STATUS = 8'hf8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned WDT_RESET_SELECT_BIT = 4;
  localparam int unsigned DEF_INTERVAL_CLEAR_BIT = 3;
  localparam int unsigned DEF_RC_SELECT_BIT = 5;
  localparam int unsigned WDT_CLEAR_BIT = 7;
  localparam int unsigned SCS_W = 2;
  localparam int unsigned STA_INTERVAL_FLAG_BIT = 0;
  localparam int unsigned STA_WATCHDOG_FLAG_BIT = 1;
  localparam int unsigned STA_RC_MODE_BIT = 2;
  localparam int unsigned STA_STOP_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_CONTROL_RST = 8'h10;
  localparam logic [7:0] WATCHDOG_COMPARE_RST = 8'h7f;
  localparam logic [1:0] SYSTEM_CLOCK_SELECT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Prescaler taps and counter widths
  // ----------------------------------------------------------------
  localparam int unsigned PRESCALE_W = 12;
  localparam int unsigned TICK_W = PRESCALE_W + 1;
  localparam logic [3:0] INTERVAL_TAP_BASE = 4'h3;
  localparam logic [3:0] SYSTEM_TAP_BASE = 4'h1;
  localparam int unsigned INTERVAL_W = 8;
  localparam int unsigned WDT_W = 7;
  localparam int unsigned INTERVAL_BURST_GAP = 7;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ITW_MODE_RUN = 2'b00,
    ITW_MODE_HOLD = 2'b01,
    ITW_MODE_RC = 2'b10
  } itw_mode_t;

endpackage

/* File: hdl/itw_prescaler.sv */
// Module: peripheral prescaler producing divide-by-power-of-two enable pulses
`timescale 1ns/1ps

module itw_prescaler
  import itw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Gate, low while the device is stopped
  input wire logic enable_in,
  // Tap k pulses once every 2**k enabled cycles
  output logic [TICK_W-1:0] tick_out
);

  logic [PRESCALE_W-1:0] count_q;

  // ------------------------------------------------------------
  // Divider chain
  // ------------------------------------------------------------

  // Counter only moves while enabled, so taps freeze in stop
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_q <= '0;
    end else if (enable_in) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Tap 0 is the undivided clock, tap k fires when the low k bits are ones
  assign tick_out[0] = enable_in;
  genvar k;
  generate
    for (k = 1; k < TICK_W; k++) begin : g_tap
      assign tick_out[k] = enable_in & (&count_q[k-1:0]);
    end
  endgenerate

endmodule

/* File: testbench/test_interval_timer_watchdog.sv */
// Testbench: self-checking bench for the interval timer watchdog block
`timescale 1ns/1ps

module test_interval_timer_watchdog
  import itw_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic stop_enter_in = 1'b0;
  logic stop_release_in = 1'b0;
  logic rc_osc_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [TICK_W-1:0] periph_tick_out;
  logic sys_clk_en_out;
  logic interval_irq_flag_out;
  logic watchdog_irq_flag_out;
  logic watchdog_reset_out;
  logic rc_mode_out;
  // Event vector: 0 reset, 1 wdt flag, 2 interval flag, 3 sys enable, 4+k tick k
  wire [TICK_W+3:0] ev = {periph_tick_out, sys_clk_en_out, interval_irq_flag_out,
                          watchdog_irq_flag_out, watchdog_reset_out};
  int miscompares = 0;
  int compares = 0;
  int rst_pulses = 0;
  logic [31:0] rd;
  logic er;

  itw_top u_itw_top (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .stop_enter_in(stop_enter_in),
    .stop_release_in(stop_release_in),
    .rc_osc_in(rc_osc_in),
    .periph_tick_out(periph_tick_out),
    .sys_clk_en_out(sys_clk_en_out),
    .interval_irq_flag_out(interval_irq_flag_out),
    .watchdog_irq_flag_out(watchdog_irq_flag_out),
    .watchdog_reset_out(watchdog_reset_out),
    .rc_mode_out(rc_mode_out)
  );

  // 100 MHz clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Count reset pulses mid-cycle, where they are settled, so no race with the scenarios
  always @(negedge sys_clk_in) begin
    if (watchdog_reset_out === 1'b1) rst_pulses++;
  end

  // ----------------------------------------------------------------
  // Reporting and shared helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    miscompares++;
    $display("unexpected %s: expected event, seen timeout", what);
    give_verdict();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_in(input string what, input int lo, input int hi, input logic [31:0] got);
    compares++;
    // An unknown value must not slip through the range test
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", what, lo, hi, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (i == 20) timeout("pready");
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                        input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask

  // Counts edges until the chosen event is seen, bounded
  task automatic wait_ev(input int s, input int bound, output int n);
    for (n = 1; n <= bound; n++) begin
      @(posedge sys_clk_in);
      if (ev[s] === 1'b1) return;
    end
    timeout("event wait");
  endtask

  // One-cycle stop entry or release pulse
  task automatic stop_pulse(input logic rel);
    @(posedge sys_clk_in);
    if (rel) stop_release_in <= 1'b1;
    else stop_enter_in <= 1'b1;
    @(posedge sys_clk_in);
    stop_release_in <= 1'b0;
    stop_enter_in <= 1'b0;
  endtask

  // Slow rc oscillator, eight clocks a period so the synchroniser keeps up
  task automatic rc_run(input int k);
    repeat (k) begin
      rc_osc_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      rc_osc_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    int n;
    wait_ev(3, 20, n);
    wait_ev(3, 20, n);
    chk("system tap after reset", 2, n);
    rd_chk(ADDR_WATCHDOG_COMPARE, 32'hff, 32'h7f, "compare reset");
    rd_chk(ADDR_SYSTEM_CLOCK_SELECT, 32'hff, 32'h0, "clock select reset");
    rd_chk(ADDR_STATUS, 32'hff, 32'h0, "status reset");
    rd_chk(8'hfc, 32'hffffffff, 32'h0, "unmapped read");
    chk("unmapped error", 1, er);
    $display("test reset values ended");
  endtask

  task automatic test_wdt_reset();
    int n;
    int p;
    // Reset-select is one out of reset, so a match must give a reset pulse
    wr(ADDR_WATCHDOG_COMPARE, 32'h82);
    wait_ev(0, 4200, n);
    rd_chk(ADDR_WATCHDOG_COMPARE, 32'hff, 32'h02, "clear bit self-clears");
    wr(ADDR_TIMER_CONTROL, 32'h18);
    wait_ev(0, 6200, n);
    chk_in("first period", 4080, 6130, n);
    p = rst_pulses;
    repeat (5) begin
      repeat (1500) @(posedge sys_clk_in);
      wr(ADDR_WATCHDOG_COMPARE, 32'h82);
    end
    chk("pulses while kicked", p, rst_pulses);
    wait_ev(0, 4200, n);
    chk_in("period after kick", 2040, 4200, n);
    // Interrupt mode: flag instead of reset
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_TIMER_CONTROL, 32'h08);
    p = rst_pulses;
    wait_ev(1, 6200, n);
    chk("pulses in irq mode", p, rst_pulses);
    repeat (20) @(posedge sys_clk_in);
    rd_chk(ADDR_STATUS, 32'h2, 32'h2, "wdt flag sticky");
    wr(ADDR_STATUS, 32'h2);
    @(posedge sys_clk_in);
    chk("wdt flag cleared", 0, watchdog_irq_flag_out);
    wr(ADDR_TIMER_CONTROL, 32'h18);
    $display("test watchdog reset ended");
  endtask

  task automatic test_interval();
    int n;
    logic [7:0] a;
    // Four tap pulses per window for every source code
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_TIMER_CONTROL, 32'h18 | c);
      apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
      a = rd[7:0];
      chk_in("count after clear", 0, 1, a);
      repeat ((32 << c) - 3) @(posedge sys_clk_in);
      apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
      chk("interval steps", 32'h4, rd[7:0] - a);
    end
    wr(ADDR_TIMER_CONTROL, 32'h18);
    wr(ADDR_STATUS, 32'h1);
    wait_ev(2, 2100, n);
    chk_in("wrap time", 2030, 2060, n);
    repeat (50) @(posedge sys_clk_in);
    rd_chk(ADDR_STATUS, 32'h1, 32'h1, "interval flag sticky");
    wr(ADDR_STATUS, 32'h1);
    @(posedge sys_clk_in);
    chk("interval flag cleared", 0, interval_irq_flag_out);
    $display("test interval ended");
  endtask

  task automatic test_stop_hold();
    int n;
    int p;
    logic [7:0] a;
    // Stop mid-period; remainder after release shows the count was held
    wr(ADDR_WATCHDOG_COMPARE, 32'h82);
    wr(ADDR_TIMER_CONTROL, 32'h18);
    repeat (3000) @(posedge sys_clk_in);
    stop_pulse(1'b0);
    p = rst_pulses;
    apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
    a = rd[7:0];
    for (n = 0; n < 6000; n++) begin
      @(posedge sys_clk_in);
      if (periph_tick_out !== '0) break;
    end
    chk("ticks in stop", 6000, n);
    rd_chk(ADDR_TIMER_CONTROL, 32'hff, a, "count in stop");
    rd_chk(ADDR_STATUS, 32'hc, 32'h8, "stop state");
    chk("pulses in stop", p, rst_pulses);
    stop_pulse(1'b1);
    wait_ev(0, 1400, n);
    chk_in("resume remainder", 900, 1300, n);
    $display("test stop hold ended");
  endtask

  task automatic test_rc_mode();
    int p;
    logic [7:0] a;
    wr(ADDR_WATCHDOG_COMPARE, 32'h81);
    wr(ADDR_TIMER_CONTROL, 32'h10 | (32'h1 << DEF_RC_SELECT_BIT));
    stop_pulse(1'b0);
    @(posedge sys_clk_in);
    chk("rc mode", 1, rc_mode_out);
    chk("ticks in rc mode", 0, periph_tick_out);
    rd_chk(ADDR_STATUS, 32'h4, 32'h4, "rc status");
    a = rd[7:0];
    apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
    a = rd[7:0];
    rc_run(10);
    apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
    chk("rc steps", 32'ha, rd[7:0] - a);
    p = rst_pulses;
    rc_run(300);
    chk_in("rc timeouts", 1, 2, rst_pulses - p);
    stop_pulse(1'b1);
    @(posedge sys_clk_in);
    chk("rc mode left", 0, rc_mode_out);
    wr(ADDR_TIMER_CONTROL, 32'h18);
    $display("test rc mode ended");
  endtask

  task automatic test_clock_taps();
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_SYSTEM_CLOCK_SELECT, s);
      rd_chk(ADDR_SYSTEM_CLOCK_SELECT, 32'h3, s, "clock select");
      wait_ev(3, 20, n);
      wait_ev(3, 20, n);
      chk("system tap spacing", 2 << s, n);
    end
    for (int k = 0; k < TICK_W; k += 4) begin
      wait_ev(4 + k, 5000, n);
      wait_ev(4 + k, 5000, n);
      chk("peripheral tap spacing", 1 << k, n);
    end
    $display("test clock taps ended");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    test_reset_values();
    test_wdt_reset();
    test_interval();
    test_stop_hold();
    test_rc_mode();
    test_clock_taps();
    give_verdict();
  end
endmodule
